// ==== core/mbra_pkg.sv ====
package mbra_pkg;
    localparam logic [15:0] MBRA_AIN_BASE = 16'h0000;
    localparam logic [15:0] MBRA_AIN_LAST = 16'h01FD;
    localparam logic [15:0] MBRA_TEST_ADDR = 16'hD73C;
    localparam logic [31:0] MBRA_TEST_VALUE = 32'h00112233;
    localparam logic [15:0] MBRA_PATH_READ_BUF = 16'hECEC;
    localparam logic [15:0] MBRA_FILE_WRITE_BUF = 16'hECEE;
    localparam logic [15:0] MBRA_PATH_READ_LEN = 16'hECF0;
    localparam logic [15:0] MBRA_FILE_WRITE_LEN = 16'hECF2;
    localparam logic [15:0] MBRA_STREAM_ENABLE = 16'h1000;
    localparam logic [15:0] MBRA_SCAN_DIV = 16'h1002;
    localparam logic [15:0] MBRA_SCAN_LIMIT = 16'h1004;
    localparam logic [15:0] MBRA_TRIG_ENABLE = 16'h1006;
    localparam logic [15:0] MBRA_SCAN_COUNT = 16'h1008;
    localparam logic [15:0] MBRA_SCAN_LIST_LEN = 16'h100A;
    localparam int MBRA_BUF_DEPTH = 8;
    localparam logic [15:0] MBRA_SCAN_DIV_RESET = 16'h0064;
    localparam logic [15:0] MBRA_EXCEPTION = 16'hFFFF;
    localparam logic [15:0] MBRA_BYTES_PER_WORD = 16'h0002;
    localparam logic [7:0] MBRA_LIST_LEN_RESET = 8'h01;
    typedef enum logic [1:0] {MBRA_IDLE, MBRA_ARMED, MBRA_RUN} mbra_state_t;
endpackage

// ==== core/mbra_scan_clock.sv ====
`timescale 1ns/1ps
module mbra_scan_clock
    import mbra_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [15:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } mbra_div_t;
    mbra_div_t s_q, s_d;

    // Emits one pulse every divisor cycles while running, at a constant rate.
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 16'h0000;
        end else if (s_q.cnt + 16'h0001 >= divisor) begin
            s_d.cnt = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// ==== core/mbra_core.sv ====
// Operation
// - Packet address decoded as is, no offset.
// - One flat map, any type anywhere.
// - Single word returned MSB then LSB.
// - Two-word values return high word first.
// - Test register reads constant 0x00112233.
// - Families step one or two addresses.
// - Buffer read repeats single address, no spill.
// - Buffer write consumes each word in order up to the set length.
// - Buffers only sequential; writing a buffer's length rewinds it to the start.
// - Scan list sampled after each scan pulse that arrives between scans.
// - Stream runs continuously until stopped.
// - Only one stream session at once.
// - Stream blocks analog reads, serves others.
// - Optional scan count ends stream automatically.
// - Optional trigger holds off first scan.
`timescale 1ns/1ps
module mbra_core
    import mbra_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic [31:0] AIN_DATA,
    input wire logic [7:0] PATH_BYTE_IN,
    input wire logic TRIGGER,
    output logic [7:0] AIN_CHANNEL,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic RSP_ERROR,
    output logic SAMPLE_STROBE,
    output logic [7:0] SAMPLE_INDEX,
    output logic STREAM_ACTIVE,
    output logic [7:0] PATH_READ_INDEX,
    output logic FILE_WRITE_VALID,
    output logic [15:0] FILE_WRITE_DATA
);
    typedef struct packed {
        mbra_state_t st;
        logic [15:0] scan_div;
        logic [15:0] scan_limit;
        logic trig_en;
        logic [15:0] scan_count;
        logic [7:0] list_len;
        logic [7:0] list_pos;
        logic sampling;
        logic [15:0] path_len;
        logic [15:0] path_ptr;
        logic [15:0] wr_len;
        logic [15:0] wr_ptr;
        logic [7:0] ain_ch;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic rsp_error;
        logic smp;
        logic [7:0] smp_idx;
        logic active;
        logic [7:0] path_idx;
        logic fw_valid;
        logic [15:0] fw_data;
    } mbra_core_t;
    mbra_core_t r_q, r_d;
    logic scan_tick;

    // Selects the requested half of a 32-bit value; even address is the high word.
    function automatic logic [15:0] word_of(input logic [31:0] v, input logic low_half);
        word_of = low_half ? v[15:0] : v[31:16];
    endfunction

    mbra_scan_clock u_scan_clock (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .run(r_q.st == MBRA_RUN),
        .divisor(r_q.scan_div),
        .tick(scan_tick)
    );

    always_comb begin
        r_d = r_q;
        r_d.rsp_valid = 1'b0;
        r_d.rsp_error = 1'b0;
        r_d.smp = 1'b0;
        r_d.fw_valid = 1'b0;
        r_d.ain_ch = REQ_ADDR[8:1];
        case (r_q.st)
            MBRA_ARMED: begin
                if (!r_q.trig_en || TRIGGER) begin
                    r_d.st = MBRA_RUN;
                end
            end
            MBRA_RUN: begin
                // A tick inside a running scan is dropped; a scan must fit in one period.
                if (scan_tick && !r_q.sampling) begin
                    r_d.sampling = 1'b1;
                    r_d.list_pos = 8'h00;
                end
                if (r_q.sampling) begin
                    r_d.smp = 1'b1;
                    r_d.smp_idx = r_q.list_pos;
                    if (r_q.list_pos + 8'h01 >= r_q.list_len) begin
                        r_d.sampling = 1'b0;
                        r_d.scan_count = r_q.scan_count + 16'h0001;
                        if (r_q.scan_limit != 16'h0000
                            && r_q.scan_count + 16'h0001 >= r_q.scan_limit) begin
                            r_d.st = MBRA_IDLE;
                        end
                    end else begin
                        r_d.list_pos = r_q.list_pos + 8'h01;
                    end
                end
            end
            default: begin
                r_d.sampling = 1'b0;
            end
        endcase
        if (REQ_VALID) begin
            r_d.rsp_valid = 1'b1;
            r_d.rsp_data = 16'h0000;
            // Addresses compared directly with the packet value.
            if (REQ_WRITE) begin
                case (REQ_ADDR)
                    MBRA_STREAM_ENABLE: begin
                        if (REQ_WDATA[0] && r_q.st == MBRA_IDLE) begin
                            r_d.st = MBRA_ARMED;
                            r_d.scan_count = 16'h0000;
                        end else if (!REQ_WDATA[0]) begin
                            r_d.st = MBRA_IDLE;
                        end else begin
                            r_d.rsp_error = 1'b1;
                        end
                    end
                    MBRA_SCAN_DIV: r_d.scan_div = REQ_WDATA;
                    MBRA_SCAN_LIMIT: r_d.scan_limit = REQ_WDATA;
                    MBRA_TRIG_ENABLE: r_d.trig_en = REQ_WDATA[0];
                    MBRA_SCAN_LIST_LEN: r_d.list_len = REQ_WDATA[7:0];
                    MBRA_PATH_READ_LEN: begin
                        r_d.path_len = REQ_WDATA;
                        r_d.path_ptr = 16'h0000;
                    end
                    MBRA_FILE_WRITE_LEN: begin
                        r_d.wr_len = REQ_WDATA;
                        r_d.wr_ptr = 16'h0000;
                    end
                    MBRA_FILE_WRITE_BUF: begin
                        // Each word within the set length goes out in order through one address.
                        if (r_q.wr_ptr + MBRA_BYTES_PER_WORD <= r_q.wr_len) begin
                            r_d.fw_valid = 1'b1;
                            r_d.fw_data = REQ_WDATA;
                            r_d.wr_ptr = r_q.wr_ptr + MBRA_BYTES_PER_WORD;
                        end else begin
                            r_d.rsp_error = 1'b1;
                        end
                    end
                    default: r_d.rsp_error = 1'b1;
                endcase
            end else begin
                if (REQ_ADDR <= MBRA_AIN_LAST) begin
                    if (r_q.st != MBRA_IDLE) begin
                        r_d.rsp_error = 1'b1;
                    end else begin
                        r_d.rsp_data = word_of(AIN_DATA, REQ_ADDR[0]);
                    end
                end else begin
                    case (REQ_ADDR)
                        MBRA_TEST_ADDR, MBRA_TEST_ADDR + 16'h0001:
                            r_d.rsp_data = word_of(MBRA_TEST_VALUE, REQ_ADDR[0]);
                        MBRA_PATH_READ_BUF: begin
                            // Buffer reads never advance into the next address.
                            r_d.rsp_data = {PATH_BYTE_IN, 8'h00};
                            r_d.path_idx = r_q.path_ptr[7:0];
                            r_d.path_ptr = r_q.path_ptr + 16'h0001;
                        end
                        MBRA_STREAM_ENABLE: r_d.rsp_data = {15'h0000, r_q.st != MBRA_IDLE};
                        MBRA_SCAN_DIV: r_d.rsp_data = r_q.scan_div;
                        MBRA_SCAN_LIMIT: r_d.rsp_data = r_q.scan_limit;
                        MBRA_TRIG_ENABLE: r_d.rsp_data = {15'h0000, r_q.trig_en};
                        MBRA_SCAN_COUNT: r_d.rsp_data = r_q.scan_count;
                        MBRA_SCAN_LIST_LEN: r_d.rsp_data = {8'h00, r_q.list_len};
                        MBRA_PATH_READ_LEN: r_d.rsp_data = r_q.path_len;
                        MBRA_FILE_WRITE_LEN: r_d.rsp_data = r_q.wr_len;
                        default: begin
                            r_d.rsp_error = 1'b1;
                            r_d.rsp_data = MBRA_EXCEPTION;
                        end
                    endcase
                end
            end
        end
        r_d.active = (r_d.st != MBRA_IDLE);
    end

    // Reset leaves the stream idle, with the default divisor and a one-entry scan list.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            r_q <= '0;
            r_q.st <= MBRA_IDLE;
            r_q.scan_div <= MBRA_SCAN_DIV_RESET;
            r_q.list_len <= MBRA_LIST_LEN_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // Data word is big-endian on the wire: RSP_DATA[15:8] leaves first.
    assign RSP_VALID = r_q.rsp_valid;
    assign RSP_DATA = r_q.rsp_data;
    assign RSP_ERROR = r_q.rsp_error;
    assign AIN_CHANNEL = r_q.ain_ch;
    assign SAMPLE_STROBE = r_q.smp;
    assign SAMPLE_INDEX = r_q.smp_idx;
    assign STREAM_ACTIVE = r_q.active;
    assign PATH_READ_INDEX = r_q.path_idx;
    assign FILE_WRITE_VALID = r_q.fw_valid;
    assign FILE_WRITE_DATA = r_q.fw_data;

    // The bench owns the request side; checks watch the block's outputs, plus r_q in chk_write_consume, chk_no_idle_sample, chk_trig_hold, chk_write_refused.
    chk_test_high: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_TEST_ADDR
        |=> RSP_DATA == 16'h0011) else $error("test high word wrong");
    chk_test_low: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_TEST_ADDR + 16'h0001
        |=> RSP_DATA == 16'h2233) else $error("test low word wrong");
    chk_ain_blocked: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR <= MBRA_AIN_LAST && STREAM_ACTIVE
        |=> RSP_ERROR) else $error("analog read served during stream");
    chk_ain_channel: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID |=> AIN_CHANNEL == $past(REQ_ADDR[8:1])) else $error("channel map");
    chk_second_start: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_STREAM_ENABLE && REQ_WDATA[0]
        && STREAM_ACTIVE |=> RSP_ERROR) else $error("second stream accepted");
    chk_len_rewind: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_PATH_READ_LEN ##1
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_PATH_READ_BUF
        |=> PATH_READ_INDEX == 8'h00) else $error("pointer not rewound");
    chk_buf_advance: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_PATH_READ_BUF ##1
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_PATH_READ_BUF
        |=> PATH_READ_INDEX == $past(PATH_READ_INDEX) + 8'h01) else $error("buffer order");
    chk_write_consume: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_FILE_WRITE_BUF
        && r_q.wr_ptr + MBRA_BYTES_PER_WORD <= r_q.wr_len
        |=> FILE_WRITE_VALID && FILE_WRITE_DATA == $past(REQ_WDATA)) else $error("write lost");
    chk_no_idle_sample: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        r_q.st == MBRA_IDLE |=> !SAMPLE_STROBE) else $error("idle sample");
    chk_unmapped: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == 16'hFFFF |=> RSP_ERROR) else $error("unmapped");
    chk_exception_data: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == 16'hFFFF
        |=> RSP_DATA == MBRA_EXCEPTION) else $error("unmapped read data");
    chk_rsp_follows: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID |=> RSP_VALID) else $error("request not answered");
    chk_rsp_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !REQ_VALID |=> !RSP_VALID && !RSP_ERROR) else $error("answer without request");
    chk_ain_served: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR <= MBRA_AIN_LAST && !STREAM_ACTIVE
        |=> !RSP_ERROR && RSP_DATA == ($past(REQ_ADDR[0]) ? $past(AIN_DATA[15:0])
        : $past(AIN_DATA[31:16]))) else $error("analog word order");
    chk_stream_start: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_STREAM_ENABLE && REQ_WDATA[0]
        && !STREAM_ACTIVE
        |=> STREAM_ACTIVE && !RSP_ERROR) else $error("stream not started");
    chk_stream_stop: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_STREAM_ENABLE && !REQ_WDATA[0]
        |=> !STREAM_ACTIVE && !RSP_ERROR) else $error("stream not stopped");
    chk_trig_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        r_q.st == MBRA_ARMED && r_q.trig_en && !TRIGGER
        && !(REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_STREAM_ENABLE)
        |=> r_q.st == MBRA_ARMED && !SAMPLE_STROBE) else $error("trigger hold-off broken");
    chk_write_refused: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_FILE_WRITE_BUF
        && r_q.wr_ptr + MBRA_BYTES_PER_WORD > r_q.wr_len
        |=> RSP_ERROR && !FILE_WRITE_VALID) else $error("write beyond length");
    chk_write_rewind: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && REQ_WRITE && REQ_ADDR == MBRA_FILE_WRITE_LEN
        && REQ_WDATA >= MBRA_BYTES_PER_WORD ##1 REQ_VALID && REQ_WRITE
        && REQ_ADDR == MBRA_FILE_WRITE_BUF
        |=> FILE_WRITE_VALID) else $error("write not rewound");
    chk_index_step: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        SAMPLE_STROBE ##1 SAMPLE_STROBE
        |-> SAMPLE_INDEX == $past(SAMPLE_INDEX) + 8'h01) else $error("scan list order");
    chk_index_first: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(SAMPLE_STROBE) |-> SAMPLE_INDEX == 8'h00) else $error("scan not from first entry");
    chk_buf_no_spill: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        REQ_VALID && !REQ_WRITE && REQ_ADDR == MBRA_PATH_READ_BUF
        |=> !RSP_ERROR && RSP_DATA == {$past(PATH_BYTE_IN), 8'h00}) else $error("buffer spilled");

    cov_trigger_start: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        r_q.st == MBRA_ARMED && r_q.trig_en && TRIGGER);
    cov_stream_start: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(STREAM_ACTIVE));
    cov_sample: cover property (@(posedge CLK_SYS) disable iff (!RESETN) SAMPLE_STROBE);
    cov_auto_stop: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        $fell(STREAM_ACTIVE) && r_q.scan_limit != 16'h0000);
    cov_file_write: cover property (@(posedge CLK_SYS) disable iff (!RESETN) FILE_WRITE_VALID);
endmodule

// ==== verification/mbra_client.sv ====
`timescale 1ns/1ps
module mbra_client
    import mbra_pkg::*;
(
    input wire logic clk,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_error,
    output logic req_valid,
    output logic req_write,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h5A5A;
        req_wdata = 16'hA5A5;
    end
    // One word access; the request is held until the answering edge has passed.
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] wd,
        output logic [15:0] rd, output logic er, output logic ok);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = wd;
        @(posedge clk);
        #1;
        ok = rsp_valid;
        rd = rsp_data;
        er = rsp_error;
    endtask
    // Released lines flip so that a stale value is never mistaken for a live one.
    task automatic idle();
        req_valid = 1'b0;
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
        @(posedge clk);
        #1;
    endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench
    import mbra_pkg::*;
;
    logic clk, rstn, rv, rw, trig, rsv, rse, ss, act, fwv;
    logic [15:0] ra, rwd, rsd, fwd, last_rd;
    logic [31:0] analog_input_value;
    logic [7:0] pbyte, sidx, pidx, exp_idx, ach;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int strobe_cnt = 0;
    function automatic logic [31:0] ain_val(input logic [7:0] ch);
        return {8'h3F, ch, ~ch, 8'hC5};
    endfunction
    assign analog_input_value = rv ? ain_val(ra[8:1]) : ~ain_val(ra[8:1]);
    mbra_core u_dut (.CLK_SYS(clk), .RESETN(rstn), .REQ_VALID(rv), .REQ_WRITE(rw),
        .REQ_ADDR(ra), .REQ_WDATA(rwd), .AIN_DATA(analog_input_value), .PATH_BYTE_IN(pbyte),
        .TRIGGER(trig), .AIN_CHANNEL(ach), .RSP_VALID(rsv), .RSP_DATA(rsd),
        .RSP_ERROR(rse), .SAMPLE_STROBE(ss), .SAMPLE_INDEX(sidx), .STREAM_ACTIVE(act),
        .PATH_READ_INDEX(pidx), .FILE_WRITE_VALID(fwv), .FILE_WRITE_DATA(fwd));
    mbra_client u_cl (.clk(clk), .rsp_valid(rsv), .rsp_data(rsd), .rsp_error(rse),
        .req_valid(rv), .req_write(rw), .req_addr(ra), .req_wdata(rwd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task stop_test();
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (ss) begin
            `CHK("sample_index", exp_idx, sidx)
            strobe_cnt++;
            exp_idx = (exp_idx == 8'h01) ? 8'h00 : 8'h01;
        end
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end
    task automatic x(input logic wr, input logic [15:0] a, input logic [15:0] wd,
        input logic [15:0] ed, input logic ee);
        logic er, ok;
        u_cl.access(wr, a, wd, last_rd, er, ok);
        `CHK("rsp_valid", 1'b1, ok)
        `CHK("rsp_error", ee, er)
        if (!wr && !ee) `CHK("rsp_data", ed, last_rd)
    endtask
    task automatic t_map();
        logic [7:0] ch;
        logic [31:0] v;
        x(1'b0, MBRA_SCAN_DIV, 16'h0000, MBRA_SCAN_DIV_RESET, 1'b0);
        x(1'b0, MBRA_SCAN_LIST_LEN, 16'h0000, {8'h00, MBRA_LIST_LEN_RESET}, 1'b0);
        x(1'b0, MBRA_STREAM_ENABLE, 16'h0000, 16'h0000, 1'b0);
        x(1'b0, MBRA_TEST_ADDR, 16'h0000, MBRA_TEST_VALUE[31:16], 1'b0);
        x(1'b0, MBRA_TEST_ADDR + 16'h0001, 16'h0000, MBRA_TEST_VALUE[15:0], 1'b0);
        x(1'b1, MBRA_TEST_ADDR, 16'h1234, 16'h0000, 1'b1);
        x(1'b0, MBRA_AIN_LAST + 16'h0001, 16'h0000, 16'h0000, 1'b1);
        `CHK("unmapped", MBRA_EXCEPTION, last_rd)
        for (int i = 0; i < 3; i++) begin
            ch = (i == 2) ? 8'hFE : i[7:0];
            v = ain_val(ch);
            x(1'b0, {7'h00, ch, 1'b0}, 16'h0000, v[31:16], 1'b0);
            `CHK("ain_channel", ch, ach)
            x(1'b0, {7'h00, ch, 1'b1}, 16'h0000, v[15:0], 1'b0);
        end
        u_cl.idle();
    endtask
    task automatic t_buf();
        x(1'b1, MBRA_PATH_READ_LEN, 16'h0008, 16'h0000, 1'b0);
        x(1'b0, MBRA_PATH_READ_LEN, 16'h0000, 16'h0008, 1'b0);
        for (int k = 0; k < 4; k++) begin
            pbyte = 8'hA0 + k[7:0];
            x(1'b0, MBRA_PATH_READ_BUF, 16'h0000, {8'hA0 + k[7:0], 8'h00}, 1'b0);
            `CHK("path_index", k[7:0], pidx)
        end
        x(1'b1, MBRA_PATH_READ_LEN, 16'h0008, 16'h0000, 1'b0);
        x(1'b0, MBRA_PATH_READ_BUF, 16'h0000, 16'hA300, 1'b0);
        `CHK("path_index", 8'h00, pidx)
        x(1'b1, MBRA_FILE_WRITE_LEN, 16'h0004, 16'h0000, 1'b0);
        x(1'b0, MBRA_FILE_WRITE_LEN, 16'h0000, 16'h0004, 1'b0);
        for (int k = 0; k < 2; k++) begin
            x(1'b1, MBRA_FILE_WRITE_BUF, 16'hC0DE + k[15:0], 16'h0000, 1'b0);
            `CHK("fw_valid", 1'b1, fwv)
            `CHK("fw_data", 16'hC0DE + k[15:0], fwd)
        end
        x(1'b1, MBRA_FILE_WRITE_BUF, 16'hBEEF, 16'h0000, 1'b1);
        `CHK("fw_valid", 1'b0, fwv)
        u_cl.idle();
    endtask
    task automatic cfg(input logic [15:0] lim, input logic [15:0] trg);
        x(1'b1, MBRA_SCAN_DIV, 16'h0004, 16'h0000, 1'b0);
        x(1'b1, MBRA_SCAN_LIST_LEN, 16'h0002, 16'h0000, 1'b0);
        x(1'b1, MBRA_SCAN_LIMIT, lim, 16'h0000, 1'b0);
        x(1'b1, MBRA_TRIG_ENABLE, trg, 16'h0000, 1'b0);
        exp_idx = 8'h00;
        x(1'b1, MBRA_STREAM_ENABLE, 16'h0001, 16'h0000, 1'b0);
    endtask
    task automatic stop();
        x(1'b1, MBRA_STREAM_ENABLE, 16'h0000, 16'h0000, 1'b0);
        x(1'b0, MBRA_STREAM_ENABLE, 16'h0000, 16'h0000, 1'b0);
        u_cl.idle();
        `CHK("active", 1'b0, act)
    endtask
    task automatic t_stream();
        cfg(16'h0000, 16'h0000);
        `CHK("active", 1'b1, act)
        x(1'b0, MBRA_STREAM_ENABLE, 16'h0000, 16'h0001, 1'b0);
        x(1'b0, MBRA_SCAN_DIV, 16'h0000, 16'h0004, 1'b0);
        x(1'b0, MBRA_SCAN_LIST_LEN, 16'h0000, 16'h0002, 1'b0);
        x(1'b0, MBRA_SCAN_LIMIT, 16'h0000, 16'h0000, 1'b0);
        x(1'b1, MBRA_STREAM_ENABLE, 16'h0001, 16'h0000, 1'b1);
        x(1'b0, MBRA_AIN_BASE, 16'h0000, 16'h0000, 1'b1);
        x(1'b0, MBRA_TEST_ADDR, 16'h0000, MBRA_TEST_VALUE[31:16], 1'b0);
        u_cl.idle();
        strobe_cnt = 0;
        repeat (80) @(posedge clk);
        #1;
        `CHK("strobes", 1'b1, strobe_cnt >= 38 && strobe_cnt <= 42)
        stop();
        cfg(16'h0003, 16'h0000);
        u_cl.idle();
        strobe_cnt = 0;
        for (int i = 0; i < 200 && act; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        `CHK("active", 1'b0, act)
        `CHK("strobes", 6, strobe_cnt)
        x(1'b0, MBRA_SCAN_COUNT, 16'h0000, 16'h0003, 1'b0);
        cfg(16'h0000, 16'h0001);
        u_cl.idle();
        strobe_cnt = 0;
        repeat (40) @(posedge clk);
        #1;
        `CHK("held", 0, strobe_cnt)
        `CHK("active", 1'b1, act)
        x(1'b0, MBRA_TRIG_ENABLE, 16'h0000, 16'h0001, 1'b0);
        x(1'b0, MBRA_STREAM_ENABLE, 16'h0000, 16'h0001, 1'b0);
        u_cl.idle();
        trig = 1'b1;
        @(posedge clk);
        #1;
        trig = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        `CHK("fired", 1'b1, strobe_cnt > 0)
        stop();
    endtask
    initial begin
        rstn = 1'b0;
        trig = 1'b0;
        pbyte = 8'h00;
        exp_idx = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_map();
        t_buf();
        t_stream();
        stop_test();
    end
endmodule
